/* File: src/trap_and_interrupt_global_control.sv */
// Global trap and interrupt control: priority level, trap flags, edge selects.
// Assumes one AHB-Lite master, a core that reports trap causes as pulses,
// and external interrupt inputs already synchronous to mclk.
// What this block does
// - Core control bit 3 reads 1 when priority level exceeds seven.
// - Priority level is the upper bit above the three low status bits.
// - Nesting disable bit 15 of control one prevents interrupt nesting.
// - Bit 14 of control one flags an accumulator A overflow trap.
// - Bit 13 of control one flags an accumulator B overflow trap.
// - Bit 12 flags a severe overflow trap of accumulator A.
// - Bit 11 flags a severe overflow trap of accumulator B.
// - Bit 10 enables the accumulator A overflow trap.
// - Bit 9 enables the accumulator B overflow trap.
// - Bit 8 enables the severe overflow trap of either accumulator.
// - Bit 7 flags a math trap from an invalid accumulator shift.
// - Bit 6 flags a math trap from division by zero.
// - Bit 4 flags any math error trap.
// - Bit 3 flags an address error trap.
// - Bit 2 flags a stack error trap.
// - Bit 1 flags an oscillator failure trap.
// - Bit 15 of control two selects the alternate vector table.
// - Read-only bit 14 of control two shows timed interrupt block.
// - Bits 2 to 0 of control two pick falling or rising edges.
// - Unimplemented bits read zero and ignore writes.
// - Low priority bits are read-only while nesting is disabled.
// - User interrupts are blocked while the upper priority bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "trap_ctl_map.svh"
module trap_and_interrupt_global_control
	import trap_ctl_pkg::*;
#(
	parameter int NUM_EXT = 3
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire trap_evt_t trap_evt,
	input wire logic trap_entry,
	input wire logic irq_entry,
	input wire logic [2:0] irq_entry_level,
	input wire logic timed_block_in,
	input wire logic [NUM_EXT-1:0] ext_irq_in,
	output logic [NUM_EXT-1:0] ext_irq_req,
	output trap_req_t trap_req,
	output logic [3:0] cpu_priority_level,
	output logic user_irq_block,
	output logic nesting_off,
	output logic alt_table_select
);
	logic prio_msb_r;
	logic [2:0] prio_low_r;
	logic [15:0] flags_r;
	logic acc_a_ovf_en_r;
	logic acc_b_ovf_en_r;
	logic severe_ovf_en_r;
	logic nesting_off_r;
	logic alt_table_r;
	logic timed_block_r;
	logic [NUM_EXT-1:0] edge_sel_r;
	logic [NUM_EXT-1:0] ext_prev_r;
	logic [NUM_EXT-1:0] ext_req_r;
	trap_req_t trap_req_r;
	logic wr_pend_r;
	logic rd_pend_r;
	logic [3:0] addr_r;
	logic hreadyout_r;
	logic [31:0] hrdata_r;
	logic accept;
	logic wr_core;
	logic wr_trap;
	logic wr_vect;
	logic wr_stat;
	logic [15:0] flag_set;
	logic [15:0] flag_clr;
	logic math_any;

	// Register index of a byte address, unmapped space folds to an illegal index.
	function automatic logic [3:0] reg_sel(input logic [31:0] a);
		reg_sel = (a[31:4] == 28'h0000000) ? a[3:0] : 4'hf;
	endfunction

	// Read view of one register; only documented bits are driven.
	function automatic logic [15:0] reg_view(input logic [3:0] idx);
		logic [15:0] v;
		v = `RST_WORD;
		unique case (idx)
			`OFF_CORE_CONTROL: v[`BIT_PRIO_MSB] = prio_msb_r;
			`OFF_TRAP_NEST_CTL:
			begin
				v = flags_r & `FLAG_MASK;
				v[`BIT_NESTING_OFF] = nesting_off_r;
				v[`BIT_ACC_A_OVF_EN] = acc_a_ovf_en_r;
				v[`BIT_ACC_B_OVF_EN] = acc_b_ovf_en_r;
				v[`BIT_SEVERE_OVF_EN] = severe_ovf_en_r;
			end
			`OFF_VECT_EDGE_CTL:
			begin
				v[`BIT_ALT_TABLE] = alt_table_r;
				v[`BIT_TIMED_BLOCK] = timed_block_r;
				v[NUM_EXT-1:0] = edge_sel_r;
			end
			`OFF_CPU_STATUS: v[`PRIO_LOW_HI:`PRIO_LOW_LO] = prio_low_r;
			default: v = `RST_WORD;
		endcase
		return v;
	endfunction

	// Address phase is taken only when the slave is selected and the bus is ready.
	assign accept = hsel && htrans[1] && hready;
	assign wr_core = wr_pend_r && (addr_r == `OFF_CORE_CONTROL);
	assign wr_trap = wr_pend_r && (addr_r == `OFF_TRAP_NEST_CTL);
	assign wr_vect = wr_pend_r && (addr_r == `OFF_VECT_EDGE_CTL);
	assign wr_stat = wr_pend_r && (addr_r == `OFF_CPU_STATUS);

	// Pending transfer; a read costs one wait state so that a write in the
	// preceding data phase is already visible, at the price of read latency.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r <= 4'h0;
			hreadyout_r <= 1'b1;
		end
		else
		begin
			wr_pend_r <= accept && hwrite;
			rd_pend_r <= accept && !hwrite;
			if (accept)
				addr_r <= reg_sel(haddr);
			hreadyout_r <= !(accept && !hwrite);
		end
	end

	// Read data is loaded in the wait cycle and held until the next read.
	always_ff @(posedge mclk)
	begin
		if (rst)
			hrdata_r <= 32'h00000000;
		else if (rd_pend_r)
			hrdata_r <= {16'h0000, reg_view(addr_r)};
	end

	// Math trap sources after their enables; shift and divide always trap.
	always_comb
	begin
		flag_set = `RST_WORD;
		flag_set[14] = trap_evt.acc_a_ovf && acc_a_ovf_en_r;
		flag_set[13] = trap_evt.acc_b_ovf && acc_b_ovf_en_r;
		flag_set[12] = trap_evt.acc_a_severe && severe_ovf_en_r;
		flag_set[11] = trap_evt.acc_b_severe && severe_ovf_en_r;
		flag_set[7] = trap_evt.bad_shift;
		flag_set[6] = trap_evt.zero_divide;
		math_any = flag_set[14] | flag_set[13] | flag_set[12] | flag_set[11]
			| flag_set[7] | flag_set[6];
		flag_set[4] = math_any;
		flag_set[3] = trap_evt.addr_fault;
		flag_set[2] = trap_evt.stack_fault;
		flag_set[1] = trap_evt.clock_loss;
	end

	// Software clears a flag by writing zero to it; writing one does nothing.
	assign flag_clr = wr_trap ? (~hwdata[15:0] & `FLAG_MASK) : `RST_WORD;

	// Sticky flags; a new cause in the clearing cycle wins over the clear.
	always_ff @(posedge mclk)
	begin
		if (rst)
			flags_r <= `RST_WORD;
		else
			flags_r <= ((flags_r & ~flag_clr) | flag_set) & `FLAG_MASK;
	end

	// Trap requests towards the trap entry logic.
	always_ff @(posedge mclk)
	begin
		if (rst)
			trap_req_r <= '0;
		else
		begin
			trap_req_r.arith <= math_any;
			trap_req_r.addr <= trap_evt.addr_fault;
			trap_req_r.stack <= trap_evt.stack_fault;
			trap_req_r.clock <= trap_evt.clock_loss;
		end
	end

	// Writable control bits of both control registers.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			nesting_off_r <= 1'b0;
			acc_a_ovf_en_r <= 1'b0;
			acc_b_ovf_en_r <= 1'b0;
			severe_ovf_en_r <= 1'b0;
			alt_table_r <= 1'b0;
			edge_sel_r <= '0;
		end
		else
		begin
			if (wr_trap)
			begin
				nesting_off_r <= hwdata[`BIT_NESTING_OFF];
				acc_a_ovf_en_r <= hwdata[`BIT_ACC_A_OVF_EN];
				acc_b_ovf_en_r <= hwdata[`BIT_ACC_B_OVF_EN];
				severe_ovf_en_r <= hwdata[`BIT_SEVERE_OVF_EN];
			end
			if (wr_vect)
			begin
				alt_table_r <= hwdata[`BIT_ALT_TABLE];
				edge_sel_r <= hwdata[NUM_EXT-1:0];
			end
		end
	end

	// Upper priority bit: trap entry sets it, software may only clear it.
	always_ff @(posedge mclk)
	begin
		if (rst)
			prio_msb_r <= 1'b0;
		else if (trap_entry)
			prio_msb_r <= 1'b1;
		else if (wr_core && !hwdata[`BIT_PRIO_MSB])
			prio_msb_r <= 1'b0;
	end

	// Low priority bits. With nesting off an accepted interrupt raises the
	// level to seven so no other user interrupt can preempt it.
	always_ff @(posedge mclk)
	begin
		if (rst)
			prio_low_r <= 3'h0;
		else if (irq_entry)
			prio_low_r <= nesting_off_r ? `PRIO_LOW_MAX : irq_entry_level;
		else if (wr_stat && !nesting_off_r)
			prio_low_r <= hwdata[`PRIO_LOW_HI:`PRIO_LOW_LO];
	end

	// Timed block status follows the core; read-only to software.
	always_ff @(posedge mclk)
	begin
		if (rst)
			timed_block_r <= 1'b0;
		else
			timed_block_r <= timed_block_in;
	end

	// One edge detector per external input. Reset loads the pin's own level,
	// so an input that idles high gives no false edge once reset is released.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT; gi++)
		begin : g_ext
			always_ff @(posedge mclk)
			begin
				if (rst)
				begin
					ext_prev_r[gi] <= ext_irq_in[gi];
					ext_req_r[gi] <= 1'b0;
				end
				else
				begin
					ext_prev_r[gi] <= ext_irq_in[gi];
					ext_req_r[gi] <= edge_sel_r[gi] ? (ext_prev_r[gi] && !ext_irq_in[gi])
						: (!ext_prev_r[gi] && ext_irq_in[gi]);
				end
			end
		end
	endgenerate

	// Outputs, every one straight from a flip-flop except hresp, which is tied to zero.
	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = 1'b0;
	assign ext_irq_req = ext_req_r;
	assign trap_req = trap_req_r;
	assign cpu_priority_level = {prio_msb_r, prio_low_r};
	assign user_irq_block = prio_msb_r;
	assign nesting_off = nesting_off_r;
	assign alt_table_select = alt_table_r;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence read_taken;
		accept && !hwrite;
	endsequence
	sequence read_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence rise_seen(int i);
		!edge_sel_r[i] && !ext_prev_r[i] && ext_irq_in[i];
	endsequence
	sequence fall_seen(int i);
		edge_sel_r[i] && ext_prev_r[i] && !ext_irq_in[i];
	endsequence

	trap_sets_msb_a: assert property (trap_entry |=> cpu_priority_level[3])
		else $error("Trap entry did not raise the priority level above seven.");
	nest_level_a: assert property (irq_entry && nesting_off |=> cpu_priority_level[2:0] == 3'h7)
		else $error("Nesting off did not force level seven on entry.");
	acc_a_flag_a: assert property (trap_evt.acc_a_ovf && acc_a_ovf_en_r |=> flags_r[14])
		else $error("Accumulator A overflow flag not set.");
	acc_b_off_a: assert property (!flags_r[13] && !(trap_evt.acc_b_ovf && acc_b_ovf_en_r)
		|=> !flags_r[13])
		else $error("Accumulator B overflow flag set without an enabled trap.");
	severe_flag_a: assert property (trap_evt.acc_b_severe && severe_ovf_en_r
		|=> flags_r[11] && flags_r[4])
		else $error("Severe overflow of B did not set its flags.");
	math_any_a: assert property (trap_evt.zero_divide |=> flags_r[6] && flags_r[4]
		##0 trap_req.arith)
		else $error("Divide by zero did not flag a math trap.");
	addr_flag_a: assert property (trap_evt.addr_fault |=> flags_r[3] && trap_req.addr)
		else $error("Address fault flag or request missing.");
	status_lock_a: assert property (wr_stat && nesting_off_r && !irq_entry
		|=> $stable(cpu_priority_level[2:0]))
		else $error("Low priority bits changed by software while nesting is off.");
	block_follow_a: assert property ($rose(user_irq_block) |-> $past(trap_entry))
		else $error("User block rose without a trap entry.");
	rise_req_a: assert property (rise_seen(0) |=> ext_irq_req[0])
		else $error("Rising edge on input zero produced no request.");
	read_wait_a: assert property (read_taken |=> read_wait)
		else $error("Read did not answer after exactly one wait state.");
	// Remaining trap causes: flag one edge later, with the request checked for stack and clock faults; A flags stay clear without an enabled cause.
	acc_b_flag_a: assert property (
		trap_evt.acc_b_ovf && acc_b_ovf_en_r |=> flags_r[13])
		else $error("Accumulator B overflow flag not set.");
	severe_a_flag_a: assert property (
		trap_evt.acc_a_severe && severe_ovf_en_r |=> flags_r[12] && flags_r[4])
		else $error("Severe overflow of A did not set its flags.");
	acc_a_off_a: assert property (
		!flags_r[14] && !(trap_evt.acc_a_ovf && acc_a_ovf_en_r) |=> !flags_r[14])
		else $error("Accumulator A overflow flag set without an enabled trap.");
	severe_off_a: assert property (
		!flags_r[12] && !(trap_evt.acc_a_severe && severe_ovf_en_r) |=> !flags_r[12])
		else $error("Severe overflow flag of A set without its enable.");
	shift_flag_a: assert property (
		trap_evt.bad_shift |=> flags_r[7] && flags_r[4])
		else $error("Bad shift did not flag a math trap.");
	stack_flag_a: assert property (
		trap_evt.stack_fault |=> flags_r[2] && trap_req.stack)
		else $error("Stack fault flag or request missing.");
	clock_flag_a: assert property (
		trap_evt.clock_loss |=> flags_r[1] && trap_req.clock)
		else $error("Clock loss flag or request missing.");
	// Control bits follow the data phase; software can never raise the upper bit.
	nest_write_a: assert property (
		wr_trap |=> nesting_off == $past(hwdata[`BIT_NESTING_OFF]))
		else $error("Nesting switch did not take the written value.");
	table_write_a: assert property (
		wr_vect |=> alt_table_select == $past(hwdata[`BIT_ALT_TABLE]))
		else $error("Vector table select did not take the written value.");
	timed_view_a: assert property (
		!rst |=> timed_block_r == $past(timed_block_in))
		else $error("Timed block status does not follow the core.");
	fall_req_a: assert property (
		fall_seen(2) |=> ext_irq_req[2])
		else $error("Falling edge on input two produced no request.");
	steady_quiet_a: assert property (
		ext_prev_r[1] == ext_irq_in[1] |=> !ext_irq_req[1])
		else $error("Request on input one without an edge.");
	gap_bits_a: assert property (
		rd_pend_r && addr_r == `OFF_TRAP_NEST_CTL |=> !hrdata[5] && !hrdata[0])
		else $error("Unimplemented trap control bits read as one.");
	msb_soft_set_a: assert property (
		wr_core && hwdata[`BIT_PRIO_MSB] && !trap_entry && !prio_msb_r |=> !user_irq_block)
		else $error("Software raised the upper priority bit.");
endmodule
`default_nettype wire

/* File: inc/trap_ctl_map.svh */
// Offsets, field positions and reset values of the trap and interrupt control block.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
`ifndef TRAP_CTL_MAP_SVH
`define TRAP_CTL_MAP_SVH
`define OFF_CORE_CONTROL 4'h0
`define OFF_TRAP_NEST_CTL 4'h4
`define OFF_VECT_EDGE_CTL 4'h8
`define OFF_CPU_STATUS 4'hc
`define BIT_PRIO_MSB 3
`define BIT_NESTING_OFF 15
`define BIT_ACC_A_OVF_EN 10
`define BIT_ACC_B_OVF_EN 9
`define BIT_SEVERE_OVF_EN 8
`define BIT_ALT_TABLE 15
`define BIT_TIMED_BLOCK 14
`define PRIO_LOW_HI 7
`define PRIO_LOW_LO 5
`define FLAG_MASK 16'h78de
`define RST_WORD 16'h0000
`define PRIO_LOW_MAX 3'h7
`endif

/* File: inc/trap_ctl_pkg.sv */
// Types shared by the trap and interrupt control block.
// Assumes the map header is compiled alongside.
package trap_ctl_pkg;
	// Trap causes reported by the arithmetic unit and the core, one-cycle pulses.
	typedef struct packed {
		logic acc_a_ovf;
		logic acc_b_ovf;
		logic acc_a_severe;
		logic acc_b_severe;
		logic bad_shift;
		logic zero_divide;
		logic addr_fault;
		logic stack_fault;
		logic clock_loss;
	} trap_evt_t;
	// Trap requests raised towards the trap entry logic, one-cycle pulses.
	typedef struct packed {
		logic arith;
		logic addr;
		logic stack;
		logic clock;
	} trap_req_t;
endpackage

/* File: sim/core_model.sv */
// Model of the CPU core beside the block: trap causes, trap entry, interrupt entry.
// Assumes the block answers trap causes with registered one-cycle trap requests.
`timescale 1ns/1ps
`default_nettype none
module core_model
	import trap_ctl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire trap_req_t trap_req,
	output trap_evt_t trap_evt,
	output logic trap_entry,
	output logic irq_entry,
	output logic [2:0] irq_entry_level,
	output logic timed_block_in
);
	// Idle levels from time zero; only trap_entry reaches the block unknown, until the first clock edge.
	initial
	begin
		trap_evt = '0;
		irq_entry = 1'b0;
		irq_entry_level = 3'h0;
		timed_block_in = 1'b0;
	end
	// Trap entry answers any trap request one cycle later.
	always_ff @(posedge mclk)
		trap_entry <= !rst && (|trap_req);
	// One-cycle burst of trap causes.
	task fire(input trap_evt_t e);
		@(posedge mclk);
		trap_evt <= e;
		@(posedge mclk);
		trap_evt <= '0;
	endtask
	// Level of the core's timed interrupt-disable, changed after a clock edge.
	task hold_block(input logic v);
		@(posedge mclk);
		timed_block_in <= v;
	endtask
	// One accepted user interrupt at the given level.
	task irq(input logic [2:0] lvl);
		@(posedge mclk);
		irq_entry <= 1'b1;
		irq_entry_level <= lvl;
		@(posedge mclk);
		irq_entry <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the trap and interrupt control block.
// Assumes the core model file and the map header are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "trap_ctl_map.svh"
module testbench
	import trap_ctl_pkg::*;
;
	logic mclk, rst, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic trap_entry, irq_entry, timed_block_in;
	logic user_irq_block, nesting_off, alt_table_select;
	logic [2:0] irq_entry_level, ext_irq_in, ext_irq_req;
	logic [3:0] cpu_priority_level;
	trap_evt_t trap_evt;
	trap_req_t trap_req;
	int errors, checks_done, cyc;
	// The single slave's ready closes the loop back to hready.
	trap_and_interrupt_global_control i_dut (.mclk, .rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .trap_evt, .trap_entry, .irq_entry, .irq_entry_level,
		.timed_block_in, .ext_irq_in, .ext_irq_req, .trap_req,
		.cpu_priority_level, .user_irq_block, .nesting_off, .alt_table_select);
	core_model i_core (.mclk, .rst, .trap_req, .trap_evt, .trap_entry,
		.irq_entry, .irq_entry_level, .timed_block_in);
	// Free-running clock, 8 ns period.
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// Hang guard: far above the roughly 150 cycles the run needs.
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			$display("[FAIL] %0t run timed out", $time);
			errors++;
			give_verdict;
		end
	end
	task give_verdict;
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task ck(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// One single AHB transfer; waits on ready rather than assuming a latency.
	task xf(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge mclk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rdv = hrdata;
		ck(hresp, 1'b0);
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		xf(1'b1, a, d);
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		xf(1'b0, a, 32'h0);
		ck(rdv, e);
	endtask
	// Reset values, write-one on flags ignored, unmapped place inert.
	task t_regs;
		rd(`OFF_CORE_CONTROL, 32'h0);
		rd(`OFF_TRAP_NEST_CTL, 32'h0);
		rd(`OFF_VECT_EDGE_CTL, 32'h0);
		wr(`OFF_TRAP_NEST_CTL, 32'hffffffff);
		rd(`OFF_TRAP_NEST_CTL, 32'h8700);
		ck(nesting_off, 1'b1);
		wr(`OFF_TRAP_NEST_CTL, 32'h0);
		wr(32'h10, 32'hffff);
		rd(32'h10, 32'h0);
		hsel <= 1'b0;
		wr(`OFF_VECT_EDGE_CTL, 32'h8000);
		hsel <= 1'b1;
		rd(`OFF_VECT_EDGE_CTL, 32'h0);
	endtask
	// Every cause at once, first with overflow traps off, then on.
	task t_traps;
		i_core.fire('1);
		#1 ck(trap_req, 4'hf);
		rd(`OFF_TRAP_NEST_CTL, 32'h00de);
		rd(`OFF_CORE_CONTROL, 32'h8);
		ck(cpu_priority_level, 4'h8);
		ck(user_irq_block, 1'b1);
		wr(`OFF_CORE_CONTROL, 32'h0);
		rd(`OFF_CORE_CONTROL, 32'h0);
		wr(`OFF_CORE_CONTROL, 32'h8);
		rd(`OFF_CORE_CONTROL, 32'h0);
		wr(`OFF_TRAP_NEST_CTL, 32'h0700);
		rd(`OFF_TRAP_NEST_CTL, 32'h0700);
		i_core.fire('1);
		rd(`OFF_TRAP_NEST_CTL, 32'h7fde);
		wr(`OFF_TRAP_NEST_CTL, 32'h0);
		wr(`OFF_CORE_CONTROL, 32'h0);
	endtask
	// Vector table select and the read-only timed block status.
	task t_ctl2;
		wr(`OFF_VECT_EDGE_CTL, 32'hffffffff);
		rd(`OFF_VECT_EDGE_CTL, 32'h8007);
		ck(alt_table_select, 1'b1);
		i_core.hold_block(1'b1);
		rd(`OFF_VECT_EDGE_CTL, 32'hc007);
		i_core.hold_block(1'b0);
		wr(`OFF_VECT_EDGE_CTL, 32'h0);
	endtask
	// Selected edge gives one pulse; the opposite edge gives none.
	task t_edge;
		for (int s = 0; s < 2; s++)
		begin
			wr(`OFF_VECT_EDGE_CTL, {29'h0, {3{s[0]}}});
			ext_irq_in <= {3{s[0]}};
			@(posedge mclk);
			ext_irq_in <= ~{3{s[0]}};
			@(posedge mclk);
			#1 ck(ext_irq_req, 3'h7);
			@(posedge mclk);
			#1 ck(ext_irq_req, 3'h0);
			@(posedge mclk);
			ext_irq_in <= {3{s[0]}};
			@(posedge mclk);
			#1 ck(ext_irq_req, 3'h0);
		end
	endtask
	// Nesting off freezes the low bits and forces level seven on entry.
	task t_nest;
		wr(`OFF_TRAP_NEST_CTL, 32'h8000);
		wr(`OFF_CPU_STATUS, 32'he0);
		rd(`OFF_CPU_STATUS, 32'h0);
		i_core.irq(3'h3);
		rd(`OFF_CPU_STATUS, 32'he0);
		ck(cpu_priority_level, 4'h7);
		wr(`OFF_TRAP_NEST_CTL, 32'h0);
		i_core.irq(3'h3);
		rd(`OFF_CPU_STATUS, 32'h60);
		wr(`OFF_CPU_STATUS, 32'hffff);
		rd(`OFF_CPU_STATUS, 32'he0);
	endtask
	// Main sequence: idle inputs, three-cycle reset, then each scenario.
	initial
	begin
		errors = 0;
		checks_done = 0;
		cyc = 0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		ext_irq_in = 3'h0;
		rst = 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		t_regs;
		t_traps;
		t_ctl2;
		t_edge;
		t_nest;
		give_verdict;
	end
endmodule
`default_nettype wire
